// ==== rtl/shift_unit_pkg.sv ====
package shift_unit_pkg;
   // ----------------------------------------------------------------------
   // widths and field layout
   // ----------------------------------------------------------------------
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned AMT_W      = 8;
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned ROT_W      = 5;
   localparam int unsigned MSB        = 31;
   localparam logic [7:0]  AMT_ZERO   = 8'h00;
   localparam logic [7:0]  AMT_WORD   = 8'h20;
   localparam logic [7:0]  AMT_WORD_1 = 8'h21;
   localparam logic [7:0]  IMM_LIMIT  = 8'hff;
   localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // operation encodings
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      op_none,
      op_arith_shift_right,
      op_logical_shift_right,
      op_logical_shift_left,
      op_rotate_right,
      op_rotate_right_extend
   } shift_op_t;

   typedef enum logic [1:0] {
      imm_shifted,
      imm_lanes_02,
      imm_lanes_13,
      imm_lanes_all
   } imm_form_t;
endpackage

// ==== rtl/barrel_core.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// combinational shifter: result and last bit shifted out
// ----------------------------------------------------------------------
module barrel_core
   import shift_unit_pkg::*;
(
   input  wire logic [31:0] src,
   input  wire shift_op_t   op,
   input  wire logic [7:0]  amt,
   input  wire logic        carry_in,
   output logic      [31:0] result,
   output logic             carry_out,
   output logic             carry_touch
);
   logic [7:0]  n_eff;
   logic [63:0] wide;
   logic [4:0]  nm1;

   // one case per shift kind; carry_touch says the carry would move
   always_comb begin
      result      = src;
      carry_out   = carry_in;
      carry_touch = 1'b0;
      n_eff       = amt;
      wide        = {src, src};
      nm1         = 5'(amt - 8'h01);
      case (op)
         op_arith_shift_right: begin
            if (amt != AMT_ZERO) begin
               carry_touch = 1'b1;
               if (amt >= AMT_WORD) begin
                  result    = {DATA_W{src[MSB]}};
                  carry_out = src[MSB];
               end else begin
                  result    = 32'($signed(src) >>> amt[4:0]);
                  carry_out = src[nm1];
               end
            end
         end
         op_logical_shift_right: begin
            if (amt != AMT_ZERO) begin
               carry_touch = 1'b1;
               if (amt >= AMT_WORD_1) begin
                  result    = ZERO_WORD;
                  carry_out = 1'b0;
               end else if (amt == AMT_WORD) begin
                  result    = ZERO_WORD;
                  carry_out = src[MSB];
               end else begin
                  result    = src >> amt[4:0];
                  carry_out = src[nm1];
               end
            end
         end
         op_logical_shift_left: begin
            if (amt != AMT_ZERO) begin
               carry_touch = 1'b1;
               if (amt >= AMT_WORD_1) begin
                  result    = ZERO_WORD;
                  carry_out = 1'b0;
               end else if (amt == AMT_WORD) begin
                  result    = ZERO_WORD;
                  carry_out = src[0];
               end else begin
                  result    = src << amt[4:0];
                  carry_out = src[5'(AMT_WORD - amt)];
               end
            end
         end
         op_rotate_right: begin
            if (amt != AMT_ZERO) begin
               carry_touch = 1'b1;
               // lengths past one word fold back by 32 steps
               n_eff = amt;
               if (n_eff > AMT_WORD) begin
                  n_eff = 8'(n_eff - AMT_WORD);
               end
               if (n_eff > AMT_WORD) begin
                  n_eff = {3'h0, n_eff[4:0]};
               end
               if (n_eff == AMT_WORD || n_eff == AMT_ZERO) begin
                  result    = src;
                  carry_out = src[MSB];
               end else begin
                  wide      = {src, src} >> n_eff[4:0];
                  result    = wide[31:0];
                  carry_out = src[5'(n_eff - 8'h01)];
               end
            end
         end
         op_rotate_right_extend: begin
            carry_touch = 1'b1;
            result      = {carry_in, src[31:1]};
            carry_out   = src[0];
         end
         default: begin
            result = src;
         end
      endcase
   end
endmodule

// ==== rtl/flexible_second_operand_shifter_carry_unit.sv ====
`timescale 1ns/100ps
// Operation
// - immediate is 8-bit value shifted anywhere
// - replicated byte immediates in lane patterns
// - logical group carry from large immediate bit31
// - shift ranges 1-32 right, 1-31 left/rotate
// - no shift passes source, source untouched
// - zero length passes value, carry kept
// - arithmetic right fills with sign bit
// - arithmetic right carry is bit n-1
// - arithmetic 32 or more gives sign
// - logical right zero fills, carry bit n-1
// - logical shift 32 or more gives zero
// - logical shift 33 or more clears carry
// - left shift carry is bit 32-n
// - rotate right wraps, carry bit n-1
// - rotate by 32 keeps value, carry bit31
// - rotate above 32 equals minus 32
// - extend rotate inserts carry, carry bit0
module flexible_second_operand_shifter_carry_unit
   import shift_unit_pkg::*;
#(
   parameter int unsigned WORD_W = DATA_W,
   parameter int unsigned LEN_W  = AMT_W
)
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        op_valid,
   input  wire logic        use_immediate,
   input  wire imm_form_t   imm_form,
   input  wire logic [7:0]  imm_byte,
   input  wire logic [4:0]  imm_rot,
   input  wire logic [31:0] source_register,
   input  wire shift_op_t   shift_op,
   input  wire logic [7:0]  shift_amt,
   input  wire logic        set_flags,
   input  wire logic        logical_group,
   output logic [31:0]      flexible_second_operand,
   output logic             carry_flag,
   output logic             carry_wr_en,
   output logic             range_error
);
   // ----------------------------------------------------------------------
   // elaboration guard
   // ----------------------------------------------------------------------
   // the shifter and immediate paths are built for one word and byte size
   if (WORD_W != DATA_W || LEN_W != AMT_W) begin : g_width_guard
      $error("unsupported word or length width");
   end

   // ----------------------------------------------------------------------
   // immediate expansion
   // ----------------------------------------------------------------------
   logic [31:0] imm_value;
   logic [63:0] imm_wide;
   logic        imm_carry_touch;

   // byte may land anywhere: rotate the zero-padded byte right
   always_comb begin
      imm_wide        = {24'h0, imm_byte, 24'h0, imm_byte} >> imm_rot;
      imm_carry_touch = 1'b0;
      case (imm_form)
         imm_shifted: begin
            imm_value       = imm_wide[31:0];
            imm_carry_touch = imm_value > {24'h0, IMM_LIMIT};
         end
         imm_lanes_02:  imm_value = {8'h00, imm_byte, 8'h00, imm_byte};
         imm_lanes_13:  imm_value = {imm_byte, 8'h00, imm_byte, 8'h00};
         imm_lanes_all: imm_value = {4{imm_byte}};
         default:       imm_value = ZERO_WORD;
      endcase
   end

   // ----------------------------------------------------------------------
   // register operand path
   // ----------------------------------------------------------------------
   logic [31:0] sh_result;
   logic        sh_carry;
   logic        sh_touch;

   // source is only read, never written back
   barrel_core u_core (
      .src         (source_register),
      .op          (shift_op),
      .amt         (shift_amt),
      .carry_in    (carry_flag),
      .result      (sh_result),
      .carry_out   (sh_carry),
      .carry_touch (sh_touch)
   );

   // out-of-range lengths are flagged but still computed, never refused
   function automatic logic amt_bad(input shift_op_t op, input logic [7:0] a);
      logic bad;
      bad = 1'b0;
      case (op)
         op_arith_shift_right, op_logical_shift_right: bad = a > AMT_WORD;
         op_logical_shift_left, op_rotate_right:       bad = a >= AMT_WORD;
         default:                                      bad = 1'b0;
      endcase
      return bad;
   endfunction

   // ----------------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------------
   logic carry_upd;

   // carry moves only on flag-setting ops that touch it
   always_comb begin
      if (use_immediate) begin
         carry_upd = set_flags && logical_group && imm_carry_touch;
      end else begin
         carry_upd = set_flags && sh_touch;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flexible_second_operand <= ZERO_WORD;
      end else if (op_valid) begin
         flexible_second_operand <= use_immediate ? imm_value : sh_result;
      end
   end

   // held carry: flag register keeps value when not written
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         carry_flag  <= 1'b0;
         carry_wr_en <= 1'b0;
      end else begin
         carry_wr_en <= op_valid && carry_upd;
         if (op_valid && carry_upd) begin
            carry_flag <= use_immediate ? imm_value[MSB] : sh_carry;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         range_error <= 1'b0;
      end else begin
         range_error <= op_valid && !use_immediate && amt_bad(shift_op, shift_amt);
      end
   end
endmodule

// ==== test/shift_checker_assertions.sv ====
`timescale 1ns/100ps
// watches the unit's ports only
module shift_checker
   import shift_unit_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        op_valid,
   input wire logic        use_immediate,
   input wire imm_form_t   imm_form,
   input wire logic [7:0]  imm_byte,
   input wire logic [4:0]  imm_rot,
   input wire logic [31:0] source_register,
   input wire shift_op_t   shift_op,
   input wire logic [7:0]  shift_amt,
   input wire logic        set_flags,
   input wire logic        logical_group,
   input wire logic [31:0] flexible_second_operand,
   input wire logic        carry_flag,
   input wire logic        carry_wr_en,
   input wire logic        range_error
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic rg;
   // register operand taken at this edge
   assign rg = op_valid & ~use_immediate;
   pass_thru_a: assert property (rg && shift_op == op_none
      |=> flexible_second_operand == $past(source_register)) else $error("pass");
   zero_len_a: assert property (rg && shift_amt == 8'h00
      && shift_op != op_rotate_right_extend |=> !carry_wr_en) else $error("zero len");
   asr_sign_a: assert property (rg && shift_op == op_arith_shift_right
      && shift_amt >= 8'h20 |=> flexible_second_operand == {32{$past(source_register[31])}})
      else $error("asr sign");
   lsr_clear_a: assert property (rg && set_flags && shift_amt > 8'h20
      && shift_op == op_logical_shift_right |=> carry_wr_en && !carry_flag) else $error("lsr");
   lsl_zero_a: assert property (rg && shift_op == op_logical_shift_left
      && shift_amt >= 8'h20 |=> flexible_second_operand == 32'h0) else $error("lsl");
   rrx_carry_a: assert property (rg && set_flags && shift_op == op_rotate_right_extend
      |=> carry_flag == $past(source_register[0])
      && flexible_second_operand[31] == $past(carry_flag)) else $error("rrx");
   carry_hold_a: assert property (!carry_wr_en |-> $stable(carry_flag))
      else $error("carry moved");
   imm_lane_a: assert property (op_valid && use_immediate && imm_form != imm_shifted
      |=> !carry_wr_en) else $error("lane carry");
endmodule
bind flexible_second_operand_shifter_carry_unit shift_checker u_chk (.clk_sys, .sys_rst, .op_valid,
   .use_immediate, .imm_form, .imm_byte, .imm_rot, .source_register, .shift_op,
   .shift_amt, .set_flags, .logical_group, .flexible_second_operand, .carry_flag,
   .carry_wr_en, .range_error);

// ==== test/flag_reg_model.sv ====
`timescale 1ns/100ps
// flag register side: counts carry writes
module flag_reg_model (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic carry_wr_en,
   output int        wr_count
);
   // a stretched pulse counts twice, so widths show up
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_count <= 0;
      end else if (carry_wr_en) begin
         wr_count <= wr_count + 1;
      end
   end
endmodule

// ==== test/flexible_second_operand_shifter_carry_unit_tb.sv ====
`timescale 1ns/100ps
module flexible_second_operand_shifter_carry_unit_tb
   import shift_unit_pkg::*;
;
   logic        clk_sys, sys_rst, op_valid, use_immediate, set_flags, logical_group;
   imm_form_t   imm_form;
   logic [7:0]  imm_byte, shift_amt;
   logic [4:0]  imm_rot;
   logic [31:0] source_register, flexible_second_operand;
   shift_op_t   shift_op;
   logic        carry_flag, carry_wr_en, range_error, cf;
   int          err_count, check_count, wr_n, wr_count;
   flexible_second_operand_shifter_carry_unit DUT (.clk_sys, .sys_rst, .op_valid, .use_immediate,
      .imm_form, .imm_byte, .imm_rot, .source_register, .shift_op, .shift_amt,
      .set_flags, .logical_group, .flexible_second_operand, .carry_flag,
      .carry_wr_en, .range_error);
   flag_reg_model u_flags (.clk_sys, .sys_rst, .carry_wr_en, .wr_count);
   task automatic test_done;
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] %0t saw %h want %h", $time, seen, want);
      end
   endtask
   // wcr = {write enable, new carry, range flag}; held carry tracked in cf
   task automatic exp3(input logic [31:0] o, input logic [2:0] wcr);
      if (wcr[2]) begin
         cf = wcr[1];
         wr_n++;
      end
      chk(flexible_second_operand, o);
      chk(carry_wr_en, wcr[2]);
      chk(carry_flag, cf);
      chk(range_error, wcr[0]);
   endtask
   // one op per two edges, answer looked at just after the taking edge
   task automatic issue(input logic im, input imm_form_t f, input logic [7:0] b,
      input logic [4:0] r, input logic [31:0] s, input shift_op_t o,
      input logic [7:0] n, input logic [1:0] fl);
      @(posedge clk_sys);
      use_immediate <= im;
      imm_form <= f;
      imm_byte <= b;
      imm_rot <= r;
      source_register <= s;
      shift_op <= o;
      shift_amt <= n;
      {set_flags, logical_group} <= fl;
      op_valid <= 1'b1;
      @(posedge clk_sys);
      op_valid <= 1'b0;
      #1;
   endtask
   task automatic rsh(input logic [31:0] s, input shift_op_t o, input logic [7:0] n);
      issue(1'b0, imm_shifted, 8'h00, 5'h00, s, o, n, 2'b11);
   endtask
   task automatic t_imm;
      issue(1'b1, imm_shifted, 8'h7f, 5'h18, 32'h0, op_none, 8'h00, 2'b11);
      exp3(32'h0000_7f00, 3'b100);
      issue(1'b1, imm_shifted, 8'h81, 5'h08, 32'h0, op_none, 8'h00, 2'b11);
      exp3(32'h8100_0000, 3'b110);
      issue(1'b1, imm_shifted, 8'h81, 5'h08, 32'h0, op_none, 8'h00, 2'b10);
      exp3(32'h8100_0000, 3'b000);
      issue(1'b1, imm_shifted, 8'hff, 5'h00, 32'h0, op_none, 8'h00, 2'b11);
      exp3(32'h0000_00ff, 3'b000);
      issue(1'b1, imm_lanes_02, 8'ha5, 5'h00, 32'h0, op_none, 8'h00, 2'b11);
      exp3(32'h00a5_00a5, 3'b000);
      issue(1'b1, imm_lanes_13, 8'ha5, 5'h00, 32'h0, op_none, 8'h00, 2'b11);
      exp3(32'ha500_a500, 3'b000);
      issue(1'b1, imm_lanes_all, 8'ha5, 5'h00, 32'h0, op_none, 8'h00, 2'b11);
      exp3(32'ha5a5_a5a5, 3'b000);
   endtask
   task automatic t_shift;
      rsh(32'h8000_0010, op_arith_shift_right, 8'h05);
      exp3(32'hfc00_0000, 3'b110);
      rsh(32'h8000_0010, op_arith_shift_right, 8'h28);
      exp3(32'hffff_ffff, 3'b111);
      rsh(32'h0000_0010, op_logical_shift_right, 8'h05);
      exp3(32'h0000_0000, 3'b110);
      rsh(32'h8000_0010, op_logical_shift_right, 8'h20);
      exp3(32'h0000_0000, 3'b110);
      rsh(32'h8000_0010, op_logical_shift_right, 8'h21);
      exp3(32'h0000_0000, 3'b101);
      rsh(32'h4000_0001, op_logical_shift_left, 8'h02);
      exp3(32'h0000_0004, 3'b110);
      rsh(32'h4000_0001, op_logical_shift_left, 8'h00);
      exp3(32'h4000_0001, 3'b000);
      rsh(32'h4000_0001, op_logical_shift_left, 8'h21);
      exp3(32'h0000_0000, 3'b101);
      issue(1'b0, imm_shifted, 8'h00, 5'h00, 32'h1, op_logical_shift_left, 8'h20, 2'b00);
      exp3(32'h0000_0000, 3'b001);
   endtask
   task automatic t_rot;
      rsh(32'h0000_0013, op_rotate_right, 8'h02);
      exp3(32'hc000_0004, 3'b110);
      rsh(32'h0000_0013, op_rotate_right, 8'h20);
      exp3(32'h0000_0013, 3'b101);
      rsh(32'h0000_0013, op_rotate_right, 8'h22);
      exp3(32'hc000_0004, 3'b111);
      rsh(32'h0000_0002, op_rotate_right_extend, 8'h01);
      exp3(32'h8000_0001, 3'b100);
      rsh(32'h0000_0003, op_rotate_right_extend, 8'h01);
      exp3(32'h0000_0001, 3'b110);
      rsh(32'h1234_5678, op_none, 8'h00);
      exp3(32'h1234_5678, 3'b000);
      repeat (2) @(posedge clk_sys);
      #1 exp3(32'h1234_5678, 3'b000);
   endtask
   // 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // cut a hang far beyond the 52 or so cycles needed
   initial begin
      #200000;
      err_count++;
      test_done;
   end
   initial begin
      {sys_rst, op_valid, use_immediate, set_flags, logical_group, cf} = 6'b100000;
      {imm_byte, imm_rot, shift_amt, source_register} = 53'h0;
      imm_form = imm_shifted;
      shift_op = op_none;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1 exp3(32'h0, 3'b000);
      t_imm;
      t_shift;
      t_rot;
      chk(wr_count, wr_n);
      test_done;
   end
endmodule
